/* File: rtl/timed_serdes_pkg.sv */
// Shared constants and types for the timed serializing pin port
package timed_serdes_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CLKBLK = 6;
  localparam int CNT_W = 16;
  localparam int XFER_W = 32;
  localparam int DIV_W = 8;
  localparam int SEL_W = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [SEL_W-1:0] CLKBLK_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [XFER_W-1:0] XFER_RESET = 32'h00000000;

  // ----------------------------------------
  // Reference clock timing
  // ----------------------------------------
  localparam longint CLK_HZ = 50_000_000;
  localparam longint REF_HZ = 100_000_000;
  // Reference slower than clk divides down; faster saturates at one tick per cycle
  localparam int REF_PER = (CLK_HZ > REF_HZ) ? int'(CLK_HZ / REF_HZ) : 1;
  localparam logic [DIV_W-1:0] REF_DIV = DIV_W'(REF_PER - 1);

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ = 2'b01,
    COND_NEQ = 2'b10
  } cond_mode_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_OUT = 3'b001,
    OP_IN = 3'b010,
    OP_GET_TS = 3'b011,
    OP_GET_CNT = 3'b100
  } port_op_e;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_WAIT = 2'b01,
    XS_SHIFT = 2'b10
  } xfer_state_e;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic dir_out;
    logic open_drain;
    logic [SEL_W-1:0] clk_sel;
    cond_mode_e cond_mode;
    logic [XFER_W-1:0] cond_val;
    logic strobe_in_en;
    logic strobe_out_en;
  } port_cfg_s;

  typedef struct packed {
    port_op_e op;
    logic [XFER_W-1:0] data;
    logic timed;
    logic [CNT_W-1:0] time_at;
  } port_req_s;

  typedef struct packed {
    logic ack;
    logic ready;
    logic [XFER_W-1:0] data;
  } port_rsp_s;

  typedef struct packed {
    logic ext_src;
    logic [DIV_W-1:0] div;
  } clkblk_cfg_s;

endpackage

/* File: rtl/clock_block.sv */
// Programmable clock block producing a one-cycle tick
`timescale 1ns/1ps
module clock_block
  import timed_serdes_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_src,
  input wire logic ext_pin,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);

  // ----------------------------------------
  // Source edge and divider
  // ----------------------------------------
  logic ext_d_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic tick_r;

  wire ext_rise = ext_pin & ~ext_d_r;
  wire src_edge = ext_src ? ext_rise : 1'b1;
  wire div_done = (div_cnt_r >= div);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d_r <= 1'b0;
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      ext_d_r <= ext_pin;
      tick_r <= src_edge & div_done;
      if (src_edge) begin
        div_cnt_r <= div_done ? '0 : div_cnt_r + 1'b1;
      end
    end
  end

  assign tick = tick_r;

endmodule

/* File: rtl/timed_serdes_pin_port.sv */
// Timed serializing pin port with clock blocks and pin sharing
`timescale 1ns/1ps
module timed_serdes_pin_port
  import timed_serdes_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire port_cfg_s cfg,
  input wire clkblk_cfg_s [NUM_CLKBLK-1:0] clkblk_cfg,
  input wire logic [NUM_CLKBLK-1:0] clk_src_pin,
  input wire logic link_en,
  input wire logic [WIDTH-1:0] claim_mask,
  input wire port_req_s req,
  output port_rsp_s rsp,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  input wire logic strobe_in,
  output logic strobe_out,
  output logic event_out
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int RATIO = XFER_W / WIDTH;
  localparam int SH_W = $clog2(RATIO) + 1;
  localparam logic [SH_W-1:0] SH_LAST = SH_W'(RATIO - 1);
  localparam logic [SH_W-1:0] SH_ONE = SH_W'(1);

  generate
    if (!(WIDTH == 1 || WIDTH == 4 || WIDTH == 8 || WIDTH == 16 ||
          WIDTH == 32)) begin : g_bad_width
      $error("Port width must be 1, 4, 8, 16 or 32");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  port_cfg_s cfg_r;
  xfer_state_e state_r;
  xfer_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] ts_r;
  logic [CNT_W-1:0] time_r;
  logic timed_r;
  logic [XFER_W-1:0] xfer_r;
  logic full_r;
  logic [XFER_W-1:0] sh_r;
  logic [SH_W-1:0] sh_cnt_r;
  logic [WIDTH-1:0] pin_out_r;
  logic [WIDTH-1:0] pin_oe_n_r;
  logic [WIDTH-1:0] drv_val_r;
  logic strobe_out_r;
  logic strobe_due_r;
  logic event_r;
  port_rsp_s rsp_r;

  // ----------------------------------------
  // Clock blocks
  // ----------------------------------------
  logic [NUM_CLKBLK-1:0] blk_tick;

  generate
    for (genvar b = 0; b < NUM_CLKBLK; b++) begin : g_clkblk
      // Block zero is pinned to the reference clock
      wire use_ext = (b == 0) ? 1'b0 : clkblk_cfg[b].ext_src;
      wire [DIV_W-1:0] use_div = (b == 0) ? REF_DIV : clkblk_cfg[b].div;
      clock_block u_blk (
        .clk(clk),
        .rst_n(rst_n),
        .ext_src(use_ext),
        .ext_pin(clk_src_pin[b]),
        .div(use_div),
        .tick(blk_tick[b])
      );
    end
  endgenerate

  // Out-of-range selection falls back to the reference block
  wire sel_ok = (cfg_r.clk_sel < SEL_W'(NUM_CLKBLK));
  wire tick = sel_ok ? blk_tick[cfg_r.clk_sel] : blk_tick[0];

  // ----------------------------------------
  // Pin ownership and conditions
  // ----------------------------------------
  wire [WIDTH-1:0] own = ~(claim_mask | {WIDTH{link_en}});
  // Unowned bits read as zero so the word keeps its full width
  wire [WIDTH-1:0] pin_val = pin_in & own;
  wire [WIDTH-1:0] cond_val = cfg_r.cond_val[WIDTH-1:0];
  wire cond_eq = (pin_val == cond_val);
  wire cond_hit = (cfg_r.cond_mode == COND_EQ) ? cond_eq :
                  (cfg_r.cond_mode == COND_NEQ) ? !cond_eq : 1'b1;
  wire strobe_ok = !cfg_r.strobe_in_en || strobe_in;
  wire time_ok = !timed_r || (cnt_r == time_r);

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire is_out = cfg_r.dir_out;
  wire op_out = (req.op == OP_OUT) && is_out;
  wire op_in = (req.op == OP_IN) && !is_out;
  wire out_take = op_out && !full_r;
  wire in_arm = op_in && !full_r && req.timed;

  // ----------------------------------------
  // Transfer paths
  // ----------------------------------------
  wire out_start = is_out && tick && full_r && time_ok &&
                   (state_r != XS_SHIFT);
  wire out_step = is_out && tick && (state_r == XS_SHIFT);
  wire out_last = out_step && (sh_cnt_r == SH_ONE);
  wire in_take = !is_out && tick && strobe_ok && cond_hit && time_ok;
  wire in_done = in_take && (sh_cnt_r == SH_LAST);
  wire [XFER_W-1:0] in_word = (sh_r >> WIDTH) | (XFER_W'(pin_val) << (XFER_W - WIDTH));
  wire [XFER_W-1:0] out_shift = (XFER_W == WIDTH) ? sh_r :
                                (sh_r >> WIDTH);
  wire [WIDTH-1:0] slice_nxt = out_start ? xfer_r[WIDTH-1:0] :
                               out_shift[WIDTH-1:0];
  wire full_set = in_done;
  wire full_clr = out_start || (op_in && full_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      XS_IDLE: begin
        if (is_out && full_r && timed_r && !time_ok) begin
          state_nxt = XS_WAIT;
        end else if (out_start && RATIO > 1) begin
          state_nxt = XS_SHIFT;
        end
      end
      XS_WAIT: begin
        if (out_start) begin
          state_nxt = (RATIO > 1) ? XS_SHIFT : XS_IDLE;
        end else if (!is_out) begin
          state_nxt = XS_IDLE;
        end
      end
      XS_SHIFT: begin
        if (out_last || !is_out) begin
          state_nxt = XS_IDLE;
        end
      end
      default: state_nxt = XS_IDLE;
    endcase
  end

  // ----------------------------------------
  // Configuration and counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= '0;
      cfg_r.clk_sel <= CLKBLK_RESET;
      cnt_r <= CNT_RESET;
      state_r <= XS_IDLE;
    end else begin
      cfg_r <= cfg;
      state_r <= state_nxt;
      if (tick) begin
        cnt_r <= cnt_r + CNT_ONE;
      end
    end
  end

  // ----------------------------------------
  // Transfer register and serializer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_r <= XFER_RESET;
      full_r <= 1'b0;
      sh_r <= XFER_RESET;
      sh_cnt_r <= '0;
      ts_r <= CNT_RESET;
      time_r <= CNT_RESET;
      timed_r <= 1'b0;
    end else begin
      // A word landing in the same cycle as a read keeps the flag set
      if (full_set) begin
        full_r <= 1'b1;
      end else if (full_clr) begin
        full_r <= 1'b0;
      end
      if (out_take) begin
        xfer_r <= req.data;
        full_r <= 1'b1;
        timed_r <= req.timed;
        time_r <= req.time_at;
      end else if (in_arm) begin
        timed_r <= 1'b1;
        time_r <= req.time_at;
      end
      if (out_start) begin
        sh_r <= xfer_r;
        sh_cnt_r <= SH_LAST;
        ts_r <= cnt_r;
        timed_r <= 1'b0;
      end else if (out_step) begin
        sh_r <= out_shift;
        sh_cnt_r <= sh_cnt_r - SH_ONE;
      end else if (in_take) begin
        sh_r <= in_word;
        sh_cnt_r <= in_done ? '0 : sh_cnt_r + SH_ONE;
        // The start time gates only the first slice; a fresh arm survives
        timed_r <= in_arm;
        if (in_done) begin
          xfer_r <= in_word;
          ts_r <= cnt_r;
        end
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      // Open drain drives only zeros; a one leaves the pin floating
      wire drv_on = is_out && own[i] &&
                    (!cfg_r.open_drain || !drv_val_r[i]);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_out_r[i] <= 1'b0;
          pin_oe_n_r[i] <= 1'b1;
        end else begin
          pin_out_r[i] <= cfg_r.open_drain ? 1'b0 : drv_val_r[i];
          pin_oe_n_r[i] <= !drv_on;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_val_r <= '0;
      strobe_due_r <= 1'b0;
      strobe_out_r <= 1'b0;
    end else begin
      if (out_start || out_step) begin
        drv_val_r <= slice_nxt;
      end
      if (tick) begin
        strobe_due_r <= cfg_r.strobe_out_en && (out_start || out_step);
      end
      strobe_out_r <= strobe_due_r;
    end
  end

  // ----------------------------------------
  // Events and processor answers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      event_r <= in_done;
      rsp_r.ack <= (req.op != OP_NONE);
      rsp_r.ready <= 1'b0;
      rsp_r.data <= XFER_RESET;
      case (req.op)
        OP_OUT: rsp_r.ready <= out_take;
        OP_IN: begin
          rsp_r.ready <= op_in && full_r;
          rsp_r.data <= xfer_r;
        end
        OP_GET_TS: begin
          rsp_r.ready <= 1'b1;
          rsp_r.data <= XFER_W'(ts_r);
        end
        OP_GET_CNT: begin
          rsp_r.ready <= 1'b1;
          rsp_r.data <= XFER_W'(cnt_r);
        end
        default: rsp_r.ready <= 1'b0;
      endcase
    end
  end

  assign rsp = rsp_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  assign strobe_out = strobe_out_r;
  assign event_out = event_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_accept;
    op_out && !full_r;
  endsequence

  sequence s_hold;
    state_r == XS_WAIT && !(tick && time_ok);
  endsequence

  property p_one_cycle;
    @(posedge clk) disable iff (!rst_n)
      req.op != OP_NONE |=> rsp.ack;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("access not answered");
  property p_open_drain;
    @(posedge clk) disable iff (!rst_n)
      $past(cfg_r.open_drain) |-> ((~pin_oe_n & pin_out) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
  property p_link_off;
    @(posedge clk) disable iff (!rst_n)
      $past(link_en) |-> &pin_oe_n;
  endproperty
  a_link_off: assert property (p_link_off) else $error("pin driven under link");
  property p_claim;
    @(posedge clk) disable iff (!rst_n)
      ($past(claim_mask) & ~pin_oe_n) == '0;
  endproperty
  a_claim: assert property (p_claim) else $error("claimed pin driven");
  property p_count;
    @(posedge clk) disable iff (!rst_n)
      tick |=> cnt_r == $past(cnt_r) + CNT_ONE;
  endproperty
  a_count: assert property (p_count) else $error("counter missed tick");
  property p_stamp;
    @(posedge clk) disable iff (!rst_n)
      event_out |-> ts_r == $past(cnt_r) && full_r;
  endproperty
  a_stamp: assert property (p_stamp) else $error("stamp not from sample edge");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      s_hold and is_out |=> state_r == XS_WAIT;
  endproperty
  a_hold: assert property (p_hold) else $error("timed output left early");
  property p_accept;
    @(posedge clk) disable iff (!rst_n)
      s_accept |=> full_r && rsp.ready;
  endproperty
  a_accept: assert property (p_accept) else $error("output word not buffered");
  property p_strobe;
    @(posedge clk) disable iff (!rst_n)
      strobe_out |-> $past(cfg_r.strobe_out_en, 2) || $past(strobe_out);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without enable");

endmodule

/* File: testbench/pin_partner.sv */
// External pin-side model: input slices, input strobe, application clock
`timescale 1ns/1ps
module pin_partner
  import timed_serdes_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input wire logic clk,
  output logic [WIDTH-1:0] pin_in,
  output logic strobe_in,
  output logic [NUM_CLKBLK-1:0] clk_src_pin
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // Pins have pull-downs, so a released line reads low
  initial begin
    pin_in = '0;
    strobe_in = 1'b0;
    clk_src_pin = '0;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Slices leave low first, strobe raised with the data
  task automatic send_word(input logic [XFER_W-1:0] w);
    for (int i = 0; i < XFER_W / WIDTH; i++) begin
      @(posedge clk);
      #1;
      pin_in = w[i*WIDTH +: WIDTH];
      strobe_in = 1'b1;
    end
    @(posedge clk);
    #1;
    pin_in = '0;
    strobe_in = 1'b0;
  endtask

  // Application clock on one source pin; it stands still between bursts
  task automatic run_clk(input int b, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk);
      #1;
      clk_src_pin[b] = ~clk_src_pin[b];
    end
  endtask

  // Level held on the input pins until changed again
  task automatic hold(input logic [WIDTH-1:0] v);
    @(posedge clk);
    #1;
    pin_in = v;
  endtask
endmodule

/* File: testbench/timed_serdes_pin_port_test.sv */
// Self-checking bench for the timed serializing pin port
`timescale 1ns/1ps
module timed_serdes_pin_port_test
  import timed_serdes_pkg::*;
;
  localparam int WIDTH = 4;
  logic clk;
  logic rst_n;
  port_cfg_s cfg;
  clkblk_cfg_s [NUM_CLKBLK-1:0] clkblk_cfg;
  logic [NUM_CLKBLK-1:0] clk_src_pin;
  logic link_en;
  logic [WIDTH-1:0] claim_mask;
  port_req_s req;
  port_rsp_s rsp;
  logic [WIDTH-1:0] pin_in;
  logic [WIDTH-1:0] pin_out;
  logic [WIDTH-1:0] pin_oe_n;
  logic strobe_in;
  logic strobe_out;
  logic event_out;
  int mismatches;
  int cmp_count;
  int cycles;
  int evt_cnt;
  int n;
  logic [XFER_W-1:0] got;
  logic [CNT_W-1:0] c0;
  logic [CNT_W-1:0] dt;

  timed_serdes_pin_port #(.WIDTH(WIDTH)) uut (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .clkblk_cfg(clkblk_cfg),
    .clk_src_pin(clk_src_pin), .link_en(link_en), .claim_mask(claim_mask),
    .req(req), .rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .strobe_in(strobe_in), .strobe_out(strobe_out), .event_out(event_out)
  );

  pin_partner #(.WIDTH(WIDTH)) partner (
    .clk(clk), .pin_in(pin_in), .strobe_in(strobe_in), .clk_src_pin(clk_src_pin)
  );

  // ----------------------------------------
  // Clock, timeout, event count
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (event_out === 1'b1) begin
      evt_cnt <= evt_cnt + 1;
    end
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      results();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [XFER_W-1:0] seen, input logic [XFER_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Request stays up until the taking edge; caller releases with rel
  task automatic access(input port_op_e op, input logic [XFER_W-1:0] d, input logic t,
                        input logic [CNT_W-1:0] at, input logic rdy);
    req = '{op: op, data: d, timed: t, time_at: at};
    @(posedge clk);
    #1;
    check(32'(rsp.ack), 32'h1);
    check(32'(rsp.ready), 32'(rdy));
    got = rsp.data;
  endtask

  task automatic rel();
    req.op = OP_NONE;
    @(posedge clk);
    #1;
    check(32'(rsp.ack), 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cfg = '0;
    cfg.strobe_in_en = 1'b1;
    clkblk_cfg = '0;
    link_en = 1'b0;
    claim_mask = '0;
    req = '0;
    rst_n = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    evt_cnt = 0;
    repeat (4) @(posedge clk);
    #1;
    check(32'(pin_oe_n), 32'hF);
    check(32'({strobe_out, event_out, rsp.ack}), 32'h0);
    rst_n = 1'b1;
    idle(2);
    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    c0 = got[CNT_W-1:0];
    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    rel();
    dt = got[CNT_W-1:0] - c0;
    check(32'(dt), 32'h1);
    access(OP_IN, '0, 1'b0, '0, 1'b0);
    access(OP_OUT, 32'h12345678, 1'b0, '0, 1'b0);
    rel();
    $display("test counter and refusal done");

    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    rel();
    c0 = got[CNT_W-1:0];
    n = evt_cnt;
    partner.send_word(32'h7E3C5A19);
    idle(4);
    check(32'(evt_cnt - n), 32'h1);
    access(OP_IN, '0, 1'b0, '0, 1'b1);
    check(got, 32'h7E3C5A19);
    access(OP_GET_TS, '0, 1'b0, '0, 1'b1);
    rel();
    dt = got[CNT_W-1:0] - c0;
    check(32'(dt >= 16'h0008 && dt <= 16'h0014), 32'h1);
    $display("test strobed input done");

    cfg.strobe_in_en = 1'b0;
    cfg.cond_mode = COND_EQ;
    cfg.cond_val = 32'h00000009;
    idle(2);
    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    rel();
    c0 = got[CNT_W-1:0];
    n = evt_cnt;
    partner.send_word(32'h99999999);
    idle(4);
    check(32'(evt_cnt - n), 32'h1);
    access(OP_IN, '0, 1'b0, '0, 1'b1);
    check(got, 32'h99999999);
    access(OP_GET_TS, '0, 1'b0, '0, 1'b1);
    rel();
    dt = got[CNT_W-1:0] - c0;
    check(32'(dt >= 16'h0008 && dt <= 16'h0014), 32'h1);
    $display("test conditional input done");

    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    c0 = got[CNT_W-1:0];
    access(OP_IN, '0, 1'b1, c0 + 16'h0010, 1'b0);
    rel();
    partner.hold(4'h9);
    idle(19);
    partner.hold(4'h0);
    access(OP_IN, '0, 1'b0, '0, 1'b1);
    check(got, 32'h99999999);
    access(OP_GET_TS, '0, 1'b0, '0, 1'b1);
    rel();
    dt = got[CNT_W-1:0] - c0;
    check(32'(dt), 32'h17);
    $display("test timed input done");

    cfg.cond_mode = COND_NEQ;
    cfg.cond_val = 32'h00000000;
    idle(2);
    n = evt_cnt;
    partner.send_word(32'h1234ABCD);
    idle(4);
    check(32'(evt_cnt - n), 32'h1);
    access(OP_IN, '0, 1'b0, '0, 1'b1);
    check(got, 32'h1234ABCD);
    rel();
    $display("test inequality input done");

    cfg.dir_out = 1'b1;
    cfg.strobe_out_en = 1'b1;
    cfg.cond_mode = COND_NONE;
    idle(3);
    check(32'(pin_oe_n), 32'h0);
    access(OP_OUT, 32'h87654321, 1'b0, '0, 1'b1);
    rel();
    n = 0;
    while (pin_out !== 4'h1 && n < 10) begin
      idle(1);
      n++;
    end
    check(32'(pin_out), 32'h1);
    for (int i = 1; i < 8; i++) begin
      idle(1);
      check(32'(pin_out), 32'(i + 1));
      if (i == 4) begin
        check(32'(strobe_out), 32'h1);
      end
    end
    access(OP_IN, '0, 1'b0, '0, 1'b0);
    rel();
    $display("test serial output done");

    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    c0 = got[CNT_W-1:0];
    access(OP_OUT, 32'h0000000E, 1'b1, c0 + 16'h001E, 1'b1);
    rel();
    n = 0;
    while (pin_out !== 4'hE && n < 60) begin
      idle(1);
      n++;
    end
    check(32'(n >= 24 && n <= 34), 32'h1);
    $display("test timed output done");

    idle(12);
    cfg.open_drain = 1'b1;
    idle(2);
    access(OP_OUT, 32'hAAAAAAAA, 1'b0, '0, 1'b1);
    rel();
    idle(14);
    check(32'(pin_oe_n), 32'hA);
    check(32'(pin_out), 32'h0);
    claim_mask = 4'h3;
    idle(3);
    check(32'(pin_oe_n), 32'hB);
    link_en = 1'b1;
    idle(3);
    check(32'(pin_oe_n), 32'hF);
    link_en = 1'b0;
    claim_mask = 4'h0;
    idle(3);
    check(32'(pin_oe_n), 32'hA);
    $display("test pin ownership done");

    cfg.dir_out = 1'b0;
    cfg.open_drain = 1'b0;
    cfg.clk_sel = 3'h1;
    clkblk_cfg[1] = '{ext_src: 1'b1, div: 8'h01};
    idle(3);
    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    rel();
    c0 = got[CNT_W-1:0];
    partner.run_clk(1, 20);
    idle(2);
    access(OP_GET_CNT, '0, 1'b0, '0, 1'b1);
    rel();
    dt = got[CNT_W-1:0] - c0;
    check(32'(dt >= 16'h0009 && dt <= 16'h000B), 32'h1);
    $display("test external clock done");
    results();
  end
endmodule
